// [hdl/dio_pkg.sv]
package dio_pkg;
	localparam int DIO_WIDTH = 8;
	localparam int DIO_PORT_WIDTH = 8;
	// register byte offsets
	localparam logic [7:0] DIO_OFF_GEN_DIR = 8'h00;
	localparam logic [7:0] DIO_OFF_GEN_OUT = 8'h04;
	localparam logic [7:0] DIO_OFF_GEN_IN = 8'h08;
	localparam logic [7:0] DIO_OFF_PPI_CTRL = 8'h0C;
	localparam logic [7:0] DIO_OFF_PORT_A = 8'h10;
	localparam logic [7:0] DIO_OFF_PORT_B = 8'h14;
	localparam logic [7:0] DIO_OFF_PORT_C = 8'h18;
	localparam logic [7:0] DIO_OFF_STATUS = 8'h1C;
	// control register fields
	localparam int DIO_CTRL_A_DIR = 0;
	localparam int DIO_CTRL_B_DIR = 1;
	localparam int DIO_CTRL_CL_DIR = 2;
	localparam int DIO_CTRL_CH_DIR = 3;
	localparam int DIO_CTRL_A_MODE = 4;
	localparam int DIO_CTRL_B_MODE = 6;
	localparam logic [7:0] DIO_CTRL_RESET = 8'h0F;
	localparam logic [7:0] DIO_ZERO8 = 8'h00;
	// third-port handshake bit positions
	localparam int DIO_HS_A_ACK = 6;
	localparam int DIO_HS_A_OBF = 7;
	localparam int DIO_HS_A_STB = 4;
	localparam int DIO_HS_A_IBF = 5;
	localparam int DIO_HS_B_STB = 2;
	localparam int DIO_HS_B_IBF = 1;
	localparam int DIO_HS_B_OBF = 1;
	localparam int DIO_HS_B_ACK = 2;
	typedef enum logic [1:0] {
		DIO_MODE_SIMPLE,
		DIO_MODE_STROBED,
		DIO_MODE_BIDIR
	} dio_mode_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dio_apb_req_t;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} dio_pins_t;
endpackage : dio_pkg

// [hdl/dio_ports.sv]
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dio_ports #(
	parameter int WIDTH = dio_pkg::DIO_WIDTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WIDTH-1:0] generalIoLinesIn,
	output logic [WIDTH-1:0] generalIoLinesOut,
	output logic [WIDTH-1:0] generalIoLinesOe,
	output logic counter0Direction,
	output logic counter1Direction,
	input wire logic [7:0] firstBytePortIn,
	output logic [7:0] firstBytePortOut,
	output logic [7:0] firstBytePortOe,
	input wire logic [7:0] secondBytePortIn,
	output logic [7:0] secondBytePortOut,
	output logic [7:0] secondBytePortOe,
	input wire logic [7:0] thirdBytePortIn,
	output logic [7:0] thirdBytePortOut,
	output logic [7:0] thirdBytePortOe
);
	////////////////////////////////////////////////////////////////////////
	logic rstMeta, rstSync;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	dio_pkg::dio_apb_req_t req;
	assign req = '{psel, penable, pwrite, paddr, pwdata};
	logic wrEn, rdEn;
	// zero-wait-state slave: access phase answered in the first cycle
	assign wrEn = req.psel && req.penable && req.pwrite && pready;
	assign rdEn = req.psel && !req.penable;

	function automatic logic [7:0] sel8(input logic [7:0] pin,
		input logic [7:0] latch, input logic [7:0] oe);
		sel8 = (pin & ~oe) | (latch & oe);
	endfunction : sel8

	////////////////////////////////////////////////////////////////////////
	logic [WIDTH-1:0] genDir, genOut;
	logic [7:0] ctrl, latA, latB, latC, inLatA, inLatB;
	logic ibfA, obfA, ibfB, obfB;
	dio_pkg::dio_mode_t modeA, modeB;
	assign modeA = dio_pkg::dio_mode_t'(ctrl[dio_pkg::DIO_CTRL_A_MODE +: 2]);
	assign modeB = dio_pkg::dio_mode_t'({1'b0, ctrl[dio_pkg::DIO_CTRL_B_MODE]});
	logic [7:0] genLevel;
	assign genLevel = sel8(generalIoLinesIn, genOut, genDir);

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			genDir <= '0;
			genOut <= '0;
		end else if (wrEn && req.paddr == dio_pkg::DIO_OFF_GEN_DIR) begin
			genDir <= req.pwdata[WIDTH-1:0];
		end else if (wrEn && req.paddr == dio_pkg::DIO_OFF_GEN_OUT) begin
			genOut <= req.pwdata[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			ctrl <= dio_pkg::DIO_CTRL_RESET;
			latA <= dio_pkg::DIO_ZERO8;
			latB <= dio_pkg::DIO_ZERO8;
			latC <= dio_pkg::DIO_ZERO8;
		end else if (wrEn) begin
			if (req.paddr == dio_pkg::DIO_OFF_PPI_CTRL) begin
				ctrl <= req.pwdata[7:0];
			end else if (req.paddr == dio_pkg::DIO_OFF_PORT_A) begin
				latA <= req.pwdata[7:0];
			end else if (req.paddr == dio_pkg::DIO_OFF_PORT_B) begin
				latB <= req.pwdata[7:0];
			end else if (req.paddr == dio_pkg::DIO_OFF_PORT_C) begin
				latC <= req.pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobed handshake: input full set by partner strobe, cleared by software read; output full set by software write, cleared by partner ack
	logic stbA, stbB, ackA, ackB, rdA, rdB, wrA, wrB;
	assign stbA = !thirdBytePortIn[dio_pkg::DIO_HS_A_STB];
	assign ackA = !thirdBytePortIn[dio_pkg::DIO_HS_A_ACK];
	assign stbB = !thirdBytePortIn[dio_pkg::DIO_HS_B_STB];
	assign ackB = !thirdBytePortIn[dio_pkg::DIO_HS_B_ACK];
	assign rdA = rdEn && !req.pwrite && req.paddr == dio_pkg::DIO_OFF_PORT_A;
	assign rdB = rdEn && !req.pwrite && req.paddr == dio_pkg::DIO_OFF_PORT_B;
	assign wrA = wrEn && req.paddr == dio_pkg::DIO_OFF_PORT_A;
	assign wrB = wrEn && req.paddr == dio_pkg::DIO_OFF_PORT_B;
	logic aIn, bIn;
	assign aIn = ctrl[dio_pkg::DIO_CTRL_A_DIR];
	assign bIn = ctrl[dio_pkg::DIO_CTRL_B_DIR];

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			ibfA <= 1'b0;
			obfA <= 1'b0;
			ibfB <= 1'b0;
			obfB <= 1'b0;
			inLatA <= dio_pkg::DIO_ZERO8;
			inLatB <= dio_pkg::DIO_ZERO8;
		end else begin
			// set wins over clear in the same cycle
			if (stbA && modeA != dio_pkg::DIO_MODE_SIMPLE
					&& (aIn || modeA == dio_pkg::DIO_MODE_BIDIR)) begin
				ibfA <= 1'b1;
				inLatA <= firstBytePortIn;
			end else if (rdA) begin
				ibfA <= 1'b0;
			end
			if (wrA && modeA != dio_pkg::DIO_MODE_SIMPLE) begin
				obfA <= 1'b1;
			end else if (ackA) begin
				obfA <= 1'b0;
			end
			if (stbB && modeB == dio_pkg::DIO_MODE_STROBED && bIn) begin
				ibfB <= 1'b1;
				inLatB <= secondBytePortIn;
			end else if (rdB) begin
				ibfB <= 1'b0;
			end
			if (wrB && modeB == dio_pkg::DIO_MODE_STROBED && !bIn) begin
				obfB <= 1'b1;
			end else if (ackB) begin
				obfB <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [7:0] oeA, oeB, oeC, hsOe, hsVal;
	always_comb begin
		hsOe = 8'h00;
		hsVal = 8'h00;
		if (modeA != dio_pkg::DIO_MODE_SIMPLE) begin
			hsOe[dio_pkg::DIO_HS_A_IBF] = 1'b1;
			hsVal[dio_pkg::DIO_HS_A_IBF] = ibfA;
			hsOe[dio_pkg::DIO_HS_A_OBF] = 1'b1;
			hsVal[dio_pkg::DIO_HS_A_OBF] = !obfA;
		end
		if (modeB == dio_pkg::DIO_MODE_STROBED) begin
			hsOe[dio_pkg::DIO_HS_B_IBF] = 1'b1;
			hsVal[dio_pkg::DIO_HS_B_IBF] = bIn ? ibfB : !obfB;
		end
		// bidirectional: port A driven only while partner acknowledges
		if (modeA == dio_pkg::DIO_MODE_BIDIR) begin
			oeA = ackA ? 8'hFF : 8'h00;
		end else begin
			oeA = aIn ? 8'h00 : 8'hFF;
		end
		oeB = bIn ? 8'h00 : 8'hFF;
		oeC = {{4{!ctrl[dio_pkg::DIO_CTRL_CH_DIR]}},
			{4{!ctrl[dio_pkg::DIO_CTRL_CL_DIR]}}};
		oeC = (oeC & ~hsOe) | hsOe;
	end

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			generalIoLinesOe <= '0;
			generalIoLinesOut <= '0;
			firstBytePortOe <= 8'h00;
			secondBytePortOe <= 8'h00;
			thirdBytePortOe <= 8'h00;
			firstBytePortOut <= 8'h00;
			secondBytePortOut <= 8'h00;
			thirdBytePortOut <= 8'h00;
			counter0Direction <= 1'b0;
			counter1Direction <= 1'b0;
		end else begin
			generalIoLinesOe <= genDir;
			generalIoLinesOut <= genOut;
			firstBytePortOe <= oeA;
			secondBytePortOe <= oeB;
			thirdBytePortOe <= oeC;
			firstBytePortOut <= latA;
			secondBytePortOut <= latB;
			thirdBytePortOut <= (latC & ~hsOe) | (hsVal & hsOe);
			// taps observe the pad level on input lines and the output latch on driven lines
			counter0Direction <= genLevel[6];
			counter1Direction <= genLevel[7];
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [31:0] rdVal;
	always_comb begin
		rdVal = 32'h0000_0000;
		if (req.paddr == dio_pkg::DIO_OFF_GEN_DIR) begin
			rdVal[WIDTH-1:0] = genDir;
		end else if (req.paddr == dio_pkg::DIO_OFF_GEN_OUT) begin
			rdVal[WIDTH-1:0] = genOut;
		end else if (req.paddr == dio_pkg::DIO_OFF_GEN_IN) begin
			rdVal[WIDTH-1:0] = genLevel;
		end else if (req.paddr == dio_pkg::DIO_OFF_PPI_CTRL) begin
			rdVal[7:0] = ctrl;
		end else if (req.paddr == dio_pkg::DIO_OFF_PORT_A) begin
			rdVal[7:0] = modeA == dio_pkg::DIO_MODE_SIMPLE
				? sel8(firstBytePortIn, latA, oeA) : inLatA;
		end else if (req.paddr == dio_pkg::DIO_OFF_PORT_B) begin
			rdVal[7:0] = modeB == dio_pkg::DIO_MODE_SIMPLE
				? sel8(secondBytePortIn, latB, oeB) : inLatB;
		end else if (req.paddr == dio_pkg::DIO_OFF_PORT_C) begin
			rdVal[7:0] = sel8(thirdBytePortIn, latC, oeC);
		end else if (req.paddr == dio_pkg::DIO_OFF_STATUS) begin
			rdVal[3:0] = {obfB, ibfB, obfA, ibfA};
		end
	end

	logic unmapped;
	assign unmapped = req.paddr > dio_pkg::DIO_OFF_STATUS
		|| req.paddr[1:0] != 2'b00;

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= rdEn;
			pslverr <= rdEn && unmapped;
			if (rdEn) begin
				prdata <= req.pwrite ? 32'h0000_0000 : rdVal;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	gen_reset_a: assert property (@(posedge clk)
		disable iff (!rstSync)
		$rose(rstSync) |-> {generalIoLinesOe, firstBytePortOe,
		secondBytePortOe, thirdBytePortOe} == 32'h0000_0000)
		else $error("lines driven right after reset");
	gen_dir_a: assert property (@(posedge clk)
		disable iff (!rstSync)
		wrEn && req.paddr == dio_pkg::DIO_OFF_GEN_DIR
		|-> ##2 generalIoLinesOe == $past(req.pwdata[WIDTH-1:0], 2))
		else $error("direction write not applied");
	ctr_tap_a: assert property (@(posedge clk)
		disable iff (!rstSync)
		!genDir[6] |=> counter0Direction == $past(generalIoLinesIn[6]))
		else $error("counter 0 direction not following line 6");
	tap_passive_a: assert property (@(posedge clk)
		disable iff (!rstSync) !genDir[7] |=> !generalIoLinesOe[7])
		else $error("tap changed line 7 behaviour");
	port_dir_a: assert property (@(posedge clk)
		disable iff (!rstSync) modeB == dio_pkg::DIO_MODE_SIMPLE && bIn
		|=> secondBytePortOe == 8'h00)
		else $error("input port driven");
	sequence strobeA_s;
		stbA && aIn && modeA == dio_pkg::DIO_MODE_STROBED;
	endsequence
	strobe_latch_a: assert property (@(posedge clk)
		disable iff (!rstSync)
		strobeA_s |=> ibfA && inLatA == $past(firstBytePortIn))
		else $error("strobe did not latch port data");
	ack_clear_a: assert property (@(posedge clk)
		disable iff (!rstSync) obfA && !ackA && !wrA |=> obfA)
		else $error("output full cleared without acknowledge");
	hs_pins_a: assert property (@(posedge clk)
		disable iff (!rstSync) modeA != dio_pkg::DIO_MODE_SIMPLE
		|=> thirdBytePortOe[dio_pkg::DIO_HS_A_IBF])
		else $error("handshake pin not driven");
	bidir_drive_a: assert property (@(posedge clk)
		disable iff (!rstSync) modeA == dio_pkg::DIO_MODE_BIDIR
		|=> firstBytePortOe == ($past(ackA) ? 8'hFF : 8'h00))
		else $error("bidirectional port driven without acknowledge");
	simple_out_a: assert property (@(posedge clk)
		disable iff (!rstSync)
		wrA |-> ##2 firstBytePortOut == $past(req.pwdata[7:0], 2))
		else $error("port output not last written value");
endmodule : dio_ports
`default_nettype wire

// [test/dio_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
module dio_far_end (
	input wire logic [7:0] genDrive,
	input wire logic [7:0] aDrive,
	input wire logic [7:0] bDrive,
	input wire logic [7:0] cDrive,
	input wire logic [7:0] genOut,
	input wire logic [7:0] genOe,
	input wire logic [7:0] aOut,
	input wire logic [7:0] aOe,
	input wire logic [7:0] bOut,
	input wire logic [7:0] bOe,
	input wire logic [7:0] cOut,
	input wire logic [7:0] cOe,
	output logic [7:0] genLevel,
	output logic [7:0] aLevel,
	output logic [7:0] bLevel,
	output logic [7:0] cLevel
);
	// the device wins a line only while it enables its driver
	assign genLevel = (genOe & genOut) | (~genOe & genDrive);
	assign aLevel = (aOe & aOut) | (~aOe & aDrive);
	assign bLevel = (bOe & bOut) | (~bOe & bDrive);
	// strobe and ack levels come from cDrive, held until the bench lets go
	assign cLevel = (cOe & cOut) | (~cOe & cDrive);
endmodule : dio_far_end
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin \
	miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module testbench;
	logic clk = 1'b0;
	logic rstB = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, lastErr;
	logic cnt0Dir, cnt1Dir;
	logic [7:0] gIn, gOut, gOe, aIn, aOut, aOe, bIn, bOut, bOe, cIn, cOut, cOe;
	logic [7:0] extGen = 8'h40, extA = 8'h00, extB = 8'h5A, extC = 8'hFF;
	int miscompares = 0, totalChecks = 0, cycles = 0;
	initial forever #20 clk = ~clk;
	dio_ports i_dio_ports (.clk(clk), .rst_b(rstB), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.generalIoLinesIn(gIn), .generalIoLinesOut(gOut),
		.generalIoLinesOe(gOe), .counter0Direction(cnt0Dir),
		.counter1Direction(cnt1Dir), .firstBytePortIn(aIn),
		.firstBytePortOut(aOut), .firstBytePortOe(aOe),
		.secondBytePortIn(bIn), .secondBytePortOut(bOut),
		.secondBytePortOe(bOe), .thirdBytePortIn(cIn),
		.thirdBytePortOut(cOut), .thirdBytePortOe(cOe));
	dio_far_end i_dio_far_end (.genDrive(extGen), .aDrive(extA),
		.bDrive(extB), .cDrive(extC), .genOut(gOut), .genOe(gOe),
		.aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe), .cOut(cOut),
		.cOe(cOe), .genLevel(gIn), .aLevel(aIn), .bLevel(bIn), .cLevel(cIn));
	task finish_test;
		if (miscompares == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	// hung handshakes end here rather than stalling the run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			finish_test();
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h00000000, r);
		`CHK(r, e)
	endtask : rd
	task settle;
		repeat (3) @(posedge clk);
	endtask : settle
	initial begin
		repeat (5) @(posedge clk);
		rstB <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK({gOe, aOe, bOe, cOe}, 32'h00000000)
		`CHK({cnt0Dir, cnt1Dir}, 2'b10)
		rd(dio_pkg::DIO_OFF_GEN_DIR, 32'h00000000);
		rd(dio_pkg::DIO_OFF_PPI_CTRL, 32'h0000000F);
		extGen <= 8'h3C;
		wr(dio_pkg::DIO_OFF_GEN_DIR, 32'h000000F0);
		wr(dio_pkg::DIO_OFF_GEN_OUT, 32'h000000A5);
		settle();
		`CHK(gOe, 8'hF0)
		`CHK(gOut & gOe, 8'hA0)
		`CHK({cnt0Dir, cnt1Dir}, 2'b01)
		rd(dio_pkg::DIO_OFF_GEN_IN, 32'h000000AC);
		`CHK(gOe, 8'hF0)
		wr(dio_pkg::DIO_OFF_PPI_CTRL, 32'h0000000E);
		wr(dio_pkg::DIO_OFF_PORT_A, 32'h00000081);
		settle();
		`CHK({aOe, aOut, bOe}, 24'hFF8100)
		rd(dio_pkg::DIO_OFF_PORT_B, 32'h0000005A);
		rd(8'h20, 32'h00000000);
		`CHK(lastErr, 1'b1)
		// strobed input on the first group
		extA <= 8'h77;
		wr(dio_pkg::DIO_OFF_PPI_CTRL, 32'h0000001F);
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000000);
		extC <= 8'hEF;
		settle();
		extC <= 8'hFF;
		settle();
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000001);
		rd(dio_pkg::DIO_OFF_PORT_A, 32'h00000077);
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000000);
		// bidirectional: the port drives only under ack
		wr(dio_pkg::DIO_OFF_PPI_CTRL, 32'h0000002F);
		wr(dio_pkg::DIO_OFF_PORT_A, 32'h0000003C);
		settle();
		`CHK(aOe, 8'h00)
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000002);
		extC <= 8'hBF;
		settle();
		`CHK({aOe, aOut}, 16'hFF3C)
		extC <= 8'hFF;
		settle();
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000000);
		// strobed input on the second group, then a reset in mid-run
		extB <= 8'hC3;
		wr(dio_pkg::DIO_OFF_PPI_CTRL, 32'h0000004F);
		extC <= 8'hFB;
		settle();
		`CHK({cOe[1], cOut[1]}, 2'b11)
		extC <= 8'hFF;
		settle();
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000004);
		rd(dio_pkg::DIO_OFF_PORT_B, 32'h000000C3);
		rd(dio_pkg::DIO_OFF_STATUS, 32'h00000000);
		rstB <= 1'b0;
		repeat (2) @(posedge clk);
		rstB <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK({gOe, aOe, bOe, cOe}, 32'h00000000)
		rd(dio_pkg::DIO_OFF_PPI_CTRL, 32'h0000000F);
		rd(dio_pkg::DIO_OFF_GEN_DIR, 32'h00000000);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
